// ==== hdl/lgp_defines.svh ====
// lgp_defines.svh: offsets, field positions and reset values for the interrupt controller pair
// assumes inclusion by bare name from design files that also import lgp_pkg
`ifndef LGP_DEFINES_SVH
`define LGP_DEFINES_SVH

// controller register offsets on the link
`define LGP_OFS_CMD          1'b0
`define LGP_OFS_DATA         1'b1

// first-word and command-word field positions
`define LGP_BIT_INIT_SEL     4
`define LGP_BIT_NEED_FOURTH  0
`define LGP_BIT_OP_WORD_POLL_SPECIALMASK_SEL     3
`define LGP_BIT_POLL         2
`define LGP_BIT_SMM_EN       6
`define LGP_BIT_SMM_VAL      5
`define LGP_BIT_RD_EN        1
`define LGP_BIT_RD_ISR       0
`define LGP_BIT_POLL_FLAG    7

// reset values and the level reported for a spurious acknowledge
`define LGP_RST_BYTE         8'h00
`define LGP_RST_VBASE        5'h00
`define LGP_RST_LOWEST       3'h7
`define LGP_SPURIOUS_LEVEL   3'h7

// host-side apb register offsets
`define LGP_APB_CMD          12'h000
`define LGP_APB_STATUS       12'h004

// host command register fields
`define LGP_CMD_ADDR         8
`define LGP_CMD_READ         9
`define LGP_CMD_ACK          10

// host status register fields
`define LGP_ST_BUSY          8
`define LGP_ST_INT           9

`endif

// ==== hdl/lgp_pkg.sv ====
// lgp_pkg: types shared by both ends of the interrupt controller link
// assumes nothing beyond a systemverilog compiler
package lgp_pkg;

  typedef enum logic [4:0] {
    LGP_UNINIT = 5'b00001,
    LGP_W2     = 5'b00010,
    LGP_W3     = 5'b00100,
    LGP_W4     = 5'b01000,
    LGP_RUN    = 5'b10000
  } lgp_init_t;

  // eoi / rotate command codes in bits 7-5 of the command word
  typedef enum logic [2:0] {
    LGP_ROT_AUTO_CLR = 3'h0,
    LGP_EOI_NS       = 3'h1,
    LGP_NOP          = 3'h2,
    LGP_EOI_SP       = 3'h3,
    LGP_ROT_AUTO_SET = 3'h4,
    LGP_ROT_EOI_NS   = 3'h5,
    LGP_SET_PRIO     = 3'h6,
    LGP_ROT_EOI_SP   = 3'h7
  } lgp_op_word_eoi_rotate_t;

  typedef enum logic [1:0] {
    LGP_H_IDLE = 2'b01,
    LGP_H_WAIT = 2'b10
  } lgp_host_st_t;

endpackage : lgp_pkg

// ==== hdl/lgp_link_if.sv ====
// lgp_link_if: byte link between the host end and one controller
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface lgp_link_if;
  logic       wr_stb;
  logic       rd_stb;
  logic       ack_stb;
  logic       addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rvalid;
  logic       int_line;

  modport dev  (input wr_stb, rd_stb, ack_stb, addr, wdata, output rdata, rvalid, int_line);
  modport host (output wr_stb, rd_stb, ack_stb, addr, wdata, input rdata, rvalid, int_line);
endinterface : lgp_link_if

// ==== hdl/lgp_prio.sv ====
// lgp_prio: rotating priority resolver over eight levels
// assumes lowest names the level that currently has priority 7
`timescale 1ns/100ps
module lgp_prio
  import lgp_pkg::*;
(
  input  logic [7:0] vec,
  input  logic [2:0] lowest,
  output logic       found,
  output logic [2:0] level,
  output logic [2:0] rank
);
  logic [7:0] rot;
  logic [2:0] idx [8];

  // rot[k] holds the level whose priority is k
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_rot
      assign idx[g] = lowest + 3'(g + 1);
      assign rot[g] = vec[idx[g]];
    end
  endgenerate

  always_comb begin
    found = 1'b0;
    rank  = 3'h0;
    for (int k = 7; k >= 0; k--) begin
      if (rot[k]) begin
        found = 1'b1;
        rank  = 3'(k);
      end
    end
    level = lowest + 3'h1 + rank;
  end
endmodule : lgp_prio

// ==== hdl/lgp_dev.sv ====
// lgp_dev: one eight-input controller with init sequencing, rotation, special mask and poll
// assumes the host issues at most one strobe per cycle on the link and samples irq_req as levels
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
`include "lgp_defines.svh"

module lgp_dev
  import lgp_pkg::*;
(
  input  logic       clock,
  input  logic       rst,
  input  logic [7:0] irq_req,
  output logic       init_done,
  lgp_link_if.dev    link
);
  lgp_init_t  st_q, st_d;
  logic [7:0] irr_q, irr_d;
  logic [7:0] isr_q, isr_d;
  logic [7:0] imr_q, imr_d;
  logic [2:0] low_q, low_d;
  logic [4:0] vbase_q, vbase_d;
  logic       need4_q, need4_d;
  logic       rot_auto_q, rot_auto_d;
  logic       smm_q, smm_d;
  logic       poll_q, poll_d;
  logic       rd_isr_q, rd_isr_d;
  logic [7:0] rdata_q, rdata_d;
  logic       rvalid_q, rvalid_d;
  logic       int_q, int_d;
  logic       done_q, done_d;

  logic [7:0] req_vec;
  logic [7:0] isr_vec;
  logic       req_found;
  logic [2:0] req_level;
  logic [2:0] req_rank;
  logic       isr_found;
  logic [2:0] isr_level;
  logic [2:0] isr_rank;
  lgp_op_word_eoi_rotate_t  cmd;
  logic [2:0] cmd_lvl;

  // in special mask mode in-service levels inhibit only themselves
  assign req_vec = smm_q ? (irr_q & ~imr_q & ~isr_q) : (irr_q & ~imr_q);
  assign isr_vec = smm_q ? (isr_q & ~imr_q) : isr_q;
  assign cmd     = lgp_op_word_eoi_rotate_t'(link.wdata[7:5]);
  assign cmd_lvl = link.wdata[2:0];

  lgp_prio u_req (
    .vec    (req_vec),
    .lowest (low_q),
    .found  (req_found),
    .level  (req_level),
    .rank   (req_rank)
  );

  lgp_prio u_isr (
    .vec    (isr_vec),
    .lowest (low_q),
    .found  (isr_found),
    .level  (isr_level),
    .rank   (isr_rank)
  );

  always_comb begin
    st_d       = st_q;
    irr_d      = irq_req;
    isr_d      = isr_q;
    imr_d      = imr_q;
    low_d      = low_q;
    vbase_d    = vbase_q;
    need4_d    = need4_q;
    rot_auto_d = rot_auto_q;
    smm_d      = smm_q;
    poll_d     = poll_q;
    rd_isr_d   = rd_isr_q;
    rdata_d    = rdata_q;
    rvalid_d   = 1'b0;
    done_d     = (st_q == LGP_RUN);

    if (link.wr_stb) begin
      if (link.addr == `LGP_OFS_CMD && link.wdata[`LGP_BIT_INIT_SEL]) begin
        // first word restarts the whole sequence
        st_d       = LGP_W2;
        need4_d    = link.wdata[`LGP_BIT_NEED_FOURTH];
        isr_d      = `LGP_RST_BYTE;
        imr_d      = `LGP_RST_BYTE;
        low_d      = `LGP_RST_LOWEST;
        rot_auto_d = 1'b0;
        smm_d      = 1'b0;
        poll_d     = 1'b0;
        rd_isr_d   = 1'b0;
      end else if (link.addr == `LGP_OFS_DATA) begin
        case (st_q)
          LGP_W2: begin
            vbase_d = link.wdata[7:3];
            st_d    = LGP_W3;
          end
          LGP_W3: begin
            st_d = need4_q ? LGP_W4 : LGP_RUN;
          end
          LGP_W4: begin
            st_d = LGP_RUN;
          end
          LGP_RUN: begin
            imr_d = link.wdata;
          end
          default: begin
            st_d = st_q;
          end
        endcase
      end else if (st_q == LGP_RUN) begin
        if (!link.wdata[`LGP_BIT_OP_WORD_POLL_SPECIALMASK_SEL]) begin
          case (cmd)
            LGP_ROT_AUTO_CLR: rot_auto_d = 1'b0;
            LGP_ROT_AUTO_SET: rot_auto_d = 1'b1;
            LGP_EOI_NS: begin
              if (isr_found) begin
                isr_d[isr_level] = 1'b0;
              end
            end
            LGP_EOI_SP: begin
              isr_d[cmd_lvl] = 1'b0;
            end
            LGP_ROT_EOI_NS: begin
              rot_auto_d = 1'b1;
              if (isr_found) begin
                isr_d[isr_level] = 1'b0;
                low_d            = isr_level;
              end
            end
            LGP_SET_PRIO: begin
              low_d = cmd_lvl;
            end
            LGP_ROT_EOI_SP: begin
              isr_d[cmd_lvl] = 1'b0;
              low_d          = cmd_lvl;
            end
            default: begin
              low_d = low_q;
            end
          endcase
        end else begin
          if (link.wdata[`LGP_BIT_SMM_EN]) begin
            smm_d = link.wdata[`LGP_BIT_SMM_VAL];
          end
          if (link.wdata[`LGP_BIT_RD_EN]) begin
            rd_isr_d = link.wdata[`LGP_BIT_RD_ISR];
          end
          poll_d = link.wdata[`LGP_BIT_POLL];
        end
      end
    end

    if (link.rd_stb) begin
      rvalid_d = 1'b1;
      if (link.addr == `LGP_OFS_DATA) begin
        rdata_d = imr_q;
      end else if (poll_q) begin
        // poll read behaves as an acknowledge
        poll_d  = 1'b0;
        rdata_d = {req_found, 4'h0, req_level};
        if (req_found) begin
          isr_d[req_level] = 1'b1;
          if (rot_auto_q) begin
            low_d = low_q;
          end
        end
      end else begin
        rdata_d = rd_isr_q ? isr_q : irr_q;
      end
    end

    if (link.ack_stb) begin
      rvalid_d = 1'b1;
      if (req_found) begin
        isr_d[req_level] = 1'b1;
        rdata_d          = {vbase_q, req_level};
      end else begin
        rdata_d = {vbase_q, `LGP_SPURIOUS_LEVEL};
      end
    end

    // raise the line when a request outranks every in-service level, or on any request in special mask mode
    int_d = (st_q == LGP_RUN) && req_found &&
            (smm_q || !isr_found || (req_rank < isr_rank));
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q       <= LGP_UNINIT;
      irr_q      <= `LGP_RST_BYTE;
      isr_q      <= `LGP_RST_BYTE;
      imr_q      <= `LGP_RST_BYTE;
      low_q      <= `LGP_RST_LOWEST;
      vbase_q    <= `LGP_RST_VBASE;
      need4_q    <= 1'b0;
      rot_auto_q <= 1'b0;
      smm_q      <= 1'b0;
      poll_q     <= 1'b0;
      rd_isr_q   <= 1'b0;
      rdata_q    <= `LGP_RST_BYTE;
      rvalid_q   <= 1'b0;
      int_q      <= 1'b0;
      done_q     <= 1'b0;
    end else begin
      st_q       <= st_d;
      irr_q      <= irr_d;
      isr_q      <= isr_d;
      imr_q      <= imr_d;
      low_q      <= low_d;
      vbase_q    <= vbase_d;
      need4_q    <= need4_d;
      rot_auto_q <= rot_auto_d;
      smm_q      <= smm_d;
      poll_q     <= poll_d;
      rd_isr_q   <= rd_isr_d;
      rdata_q    <= rdata_d;
      rvalid_q   <= rvalid_d;
      int_q      <= int_d;
      done_q     <= done_d;
    end
  end

  assign link.rdata    = rdata_q;
  assign link.rvalid   = rvalid_q;
  assign link.int_line = int_q;
  assign init_done     = done_q;
endmodule : lgp_dev

// ==== hdl/lgp_host.sv ====
// lgp_host: apb slave that turns software orders into link strobes for one controller
// assumes an apb master on the same clock; software sequences the init words itself
`timescale 1ns/100ps
`include "lgp_defines.svh"
module lgp_host
  import lgp_pkg::*;
(
  input  logic        clock,
  input  logic        rst,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [11:0] paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  output logic        int_pending,
  lgp_link_if.host    link
);
  lgp_host_st_t st_q, st_d;
  logic [31:0]  prdata_q, prdata_d;
  logic         pready_q, pready_d;
  logic         pslverr_q, pslverr_d;
  logic         wr_q, wr_d;
  logic         rd_q, rd_d;
  logic         ack_q, ack_d;
  logic         addr_q, addr_d;
  logic [7:0]   wdata_q, wdata_d;
  logic [7:0]   last_q, last_d;
  logic         int_q, int_d;
  logic         acc;

  assign acc = psel && penable && !pready_q;

  always_comb begin
    st_d      = st_q;
    prdata_d  = prdata_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    wr_d      = 1'b0;
    rd_d      = 1'b0;
    ack_d     = 1'b0;
    addr_d    = addr_q;
    wdata_d   = wdata_q;
    last_d    = last_q;
    int_d     = link.int_line;

    if (st_q == LGP_H_WAIT && link.rvalid) begin
      last_d = link.rdata;
      st_d   = LGP_H_IDLE;
    end

    if (acc) begin
      prdata_d = 32'h0000_0000;
      case (paddr)
        `LGP_APB_CMD: begin
          if (!pwrite) begin
            pready_d = 1'b1;
          end else if (st_q == LGP_H_IDLE) begin
            // order the link operation; software keeps init order
            pready_d = 1'b1;
            addr_d   = pwdata[`LGP_CMD_ADDR];
            wdata_d  = pwdata[7:0];
            if (pwdata[`LGP_CMD_ACK]) begin
              ack_d = 1'b1;
              st_d  = LGP_H_WAIT;
            end else if (pwdata[`LGP_CMD_READ]) begin
              rd_d = 1'b1;
              st_d = LGP_H_WAIT;
            end else begin
              wr_d = 1'b1;
            end
          end
        end
        `LGP_APB_STATUS: begin
          pready_d = 1'b1;
          prdata_d = {22'h00_0000, int_q, (st_q == LGP_H_WAIT), last_q};
        end
        default: begin
          pready_d  = 1'b1;
          pslverr_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q      <= LGP_H_IDLE;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      wr_q      <= 1'b0;
      rd_q      <= 1'b0;
      ack_q     <= 1'b0;
      addr_q    <= 1'b0;
      wdata_q   <= `LGP_RST_BYTE;
      last_q    <= `LGP_RST_BYTE;
      int_q     <= 1'b0;
    end else begin
      st_q      <= st_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      wr_q      <= wr_d;
      rd_q      <= rd_d;
      ack_q     <= ack_d;
      addr_q    <= addr_d;
      wdata_q   <= wdata_d;
      last_q    <= last_d;
      int_q     <= int_d;
    end
  end

  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign int_pending  = int_q;
  assign link.wr_stb  = wr_q;
  assign link.rd_stb  = rd_q;
  assign link.ack_stb = ack_q;
  assign link.addr    = addr_q;
  assign link.wdata   = wdata_q;
endmodule : lgp_host

// ==== verif/lgp_link_assertions.sv ====
// lgp_link_assertions: checks on the link between the host end and one controller
// assumes instantiation beside the interface, on the clock shared by both ends
`timescale 1ns/100ps
module lgp_link_assertions (
  input logic       clock,
  input logic       rst,
  input logic       wr_stb,
  input logic       rd_stb,
  input logic       ack_stb,
  input logic       addr,
  input logic [7:0] wdata,
  input logic [7:0] rdata,
  input logic       rvalid,
  input logic       int_line
);
  logic [2:0] st_q, st_d;
  logic       four_q, four_d, poll_q, poll_d;
  logic [4:0] vb_q, vb_d;
  logic       init_w, data_w;
  assign init_w = wr_stb && !addr && wdata[4];
  assign data_w = wr_stb && addr;
  // init sequence tracker: 1..3 waiting for words two to four, 4 running
  always_comb begin
    st_d = st_q;
    four_d = four_q;
    vb_d = vb_q;
    poll_d = poll_q && !(rd_stb && !addr);
    if (init_w) begin
      st_d = 3'h1;
      four_d = wdata[0];
      poll_d = 1'b0;
    end else if (data_w && st_q == 3'h1) begin
      st_d = 3'h2;
      vb_d = wdata[7:3];
    end else if (data_w && st_q == 3'h2) begin
      st_d = four_q ? 3'h3 : 3'h4;
    end else if (data_w && st_q == 3'h3) begin
      st_d = 3'h4;
    end else if (wr_stb && !addr && wdata[3] && st_q == 3'h4) begin
      poll_d = wdata[2];
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q <= 3'h0;
      four_q <= 1'b0;
      poll_q <= 1'b0;
      vb_q <= 5'h00;
    end else begin
      st_q <= st_d;
      four_q <= four_d;
      poll_q <= poll_d;
      vb_q <= vb_d;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_req;
    rd_stb || ack_stb;
  endsequence
  sequence s_ans;
    rvalid ##1 !rvalid;
  endsequence
  property p_answer;
    s_req |=> s_ans;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer one cycle after read");
  property p_stray;
    rvalid |-> $past(rd_stb || ack_stb);
  endproperty
  a_stray: assert property (p_stray) else $error("answer without request");
  property p_one;
    $onehot0({wr_stb, rd_stb, ack_stb});
  endproperty
  a_one: assert property (p_one) else $error("two strobes in one cycle");
  property p_hold;
    $changed(rdata) |-> rvalid;
  endproperty
  a_hold: assert property (p_hold) else $error("answer byte moved between answers");
  property p_poll;
    rd_stb && !addr && poll_q |=> rdata[6:3] == 4'h0;
  endproperty
  a_poll: assert property (p_poll) else $error("poll byte middle bits set");
  property p_vbase;
    ack_stb |=> rdata[7:3] == vb_q;
  endproperty
  a_vbase: assert property (p_vbase) else $error("vector base differs from second word");
  property p_quiet;
    $past(st_q) != 3'h4 |-> !int_line;
  endproperty
  a_quiet: assert property (p_quiet) else $error("interrupt before init complete");
  property p_restart;
    init_w |-> ##2 !int_line [*2];
  endproperty
  a_restart: assert property (p_restart) else $error("first word did not restart");
endmodule : lgp_link_assertions

// ==== verif/legacy_irq_priority_and_init_tb.sv ====
// legacy_irq_priority_and_init_tb: apb tests of host end and controller joined by the link
// assumes the design files and the link checker are compiled before it
`timescale 1ns/100ps
`include "lgp_defines.svh"
module legacy_irq_priority_and_init_tb
  import lgp_pkg::*;
;
  logic        clock, rst, psel, penable, pwrite, pready, pslverr, int_pending, init_done, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  irq_req, b;
  int          miscompares, n_tests;
  lgp_link_if link ();
  lgp_host u_lgp_host (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .int_pending(int_pending), .link(link.host));
  lgp_dev u_lgp_dev (.clock(clock), .rst(rst), .irq_req(irq_req), .init_done(init_done), .link(link.dev));
  lgp_link_assertions u_lgp_link_assertions (.clock(clock), .rst(rst), .wr_stb(link.wr_stb),
    .rd_stb(link.rd_stb), .ack_stb(link.ack_stb), .addr(link.addr), .wdata(link.wdata),
    .rdata(link.rdata), .rvalid(link.rvalid), .int_line(link.int_line));
  initial clock = 1'b0;
  always #20 clock = ~clock;
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    perr = pslverr;
    if (n >= 50) begin
      miscompares++;
      $display("[FAIL] %0t apb timeout", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  task automatic lw(input logic a1, input logic [7:0] v);
    apb(1'b1, `LGP_APB_CMD, {23'h0, a1, v});
  endtask : lw
  task automatic lr(input logic [1:0] k, input logic a1, output logic [7:0] v);
    int n;
    apb(1'b1, `LGP_APB_CMD, {21'h0, k, a1, 8'h00});
    n = 0;
    do begin
      apb(1'b0, `LGP_APB_STATUS, 32'h0);
      n++;
    end while (rd[8] !== 1'b0 && n < 20);
    if (rd[8] !== 1'b0) begin
      miscompares++;
      $display("[FAIL] %0t link answer timeout", $time);
    end
    v = rd[7:0];
  endtask : lr
  task automatic ack(input logic [7:0] e);
    lr(2'b10, 1'b0, b);
    chk(b, e);
  endtask : ack
  task automatic in_service_latch(input logic [7:0] e);
    lw(1'b0, 8'h0b);
    lr(2'b01, 1'b0, b);
    chk(b, e);
  endtask : in_service_latch
  task automatic init(input logic [4:0] vb);
    lw(1'b0, 8'h11);
    lw(1'b1, {vb, 3'h0});
    lw(1'b1, 8'h00);
    chk(init_done, 1'b0);
    lw(1'b1, 8'h01);
    @(posedge clock);
    chk(init_done, 1'b1);
    repeat (2) @(posedge clock);
  endtask : init
  initial begin
    #2000000;
    miscompares++;
    $display("[FAIL] %0t watchdog", $time);
    summarize();
  end
  initial begin
    miscompares = 0;
    n_tests = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    irq_req = 8'h00;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    irq_req <= 8'h10;
    lw(1'b0, 8'h0b);
    lw(1'b1, 8'h00);
    chk(int_pending, 1'b0);
    init(5'h03);
    chk(int_pending, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    chk(perr, 1'b1);
    chk(rd, 32'h0);
    lw(1'b1, 8'h5a);
    lr(2'b01, 1'b1, b);
    chk(b, 8'h5a);
    apb(1'b0, `LGP_APB_CMD, 32'h0);
    chk(rd, 32'h0);
    chk(perr, 1'b0);
    lw(1'b0, 8'h0a);
    irq_req <= 8'h24;
    lr(2'b01, 1'b0, b);
    chk(b, 8'h24);
    lw(1'b1, 8'h00);
    irq_req <= 8'h20;
    ack(8'h1d);
    irq_req <= 8'h24;
    ack(8'h1a);
    in_service_latch(8'h24);
    lw(1'b0, 8'h20);
    in_service_latch(8'h20);
    lw(1'b0, 8'ha0);
    in_service_latch(8'h00);
    irq_req <= 8'hff;
    lw(1'b0, 8'h80);
    for (int i = 6; i < 9; i++) begin
      ack({5'h03, i[2:0]});
      lw(1'b0, 8'ha0);
    end
    lw(1'b0, 8'h00);
    lw(1'b0, 8'h40);
    ack(8'h19);
    lw(1'b0, 8'h61);
    lw(1'b0, 8'hc5);
    ack(8'h1e);
    lw(1'b0, 8'h66);
    in_service_latch(8'h00);
    irq_req <= 8'h81;
    ack(8'h1f);
    lw(1'b0, 8'he7);
    in_service_latch(8'h00);
    ack(8'h18);
    lw(1'b0, 8'h60);
    irq_req <= 8'hff;
    lw(1'b0, 8'h68);
    ack(8'h18);
    lw(1'b1, 8'h02);
    ack(8'h1a);
    lw(1'b0, 8'h48);
    lw(1'b1, 8'h00);
    lw(1'b0, 8'h60);
    lw(1'b0, 8'h62);
    irq_req <= 8'h08;
    lw(1'b0, 8'h0c);
    lr(2'b01, 1'b0, b);
    chk(b, 8'h83);
    in_service_latch(8'h08);
    lw(1'b0, 8'h63);
    lw(1'b0, 8'h11);
    repeat (2) @(posedge clock);
    chk(int_pending, 1'b0);
    chk(init_done, 1'b0);
    init(5'h01);
    ack(8'h0b);
    lr(2'b01, 1'b1, b);
    chk(b, 8'h00);
    summarize();
  end
endmodule : legacy_irq_priority_and_init_tb
